// file: src/pra_read_address.sv
`timescale 1ns/1ps
module pra_read_address (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // read cycle request from the port sequencer
   input wire logic readCycle,
   // parallel bus outputs
   output logic [15:0] busAddress,
   output logic readChipSelectOne,
   output logic readChipSelectTwo,
   output logic readTargetActive
);
   logic [15:0] readTargetAddress;
   logic [15:0] portControlLow;
   logic [15:0] portControlHigh;
   logic readCycleMeta;
   logic readCycleSync;

   wire logic setupPhase = psel & ~penable;
   wire logic accessDone = psel & penable & pready;
   wire logic hitTarget = (paddr == pra_pkg::ADDR_READ_TARGET);
   wire logic hitLow = (paddr == pra_pkg::ADDR_PORT_CONTROL_LOW);
   wire logic hitHigh = (paddr == pra_pkg::ADDR_PORT_CONTROL_HIGH);
   wire logic hitStatus = (paddr == pra_pkg::ADDR_BUS_STATUS);
   wire logic mapped = hitTarget | hitLow | hitHigh | hitStatus;
   wire logic doWrite = accessDone & pwrite & ~pslverr;
   wire logic [1:0] csFunction = portControlLow[pra_pkg::CSF_LSB +: 2];
   wire logic dualBuffer = portControlHigh[pra_pkg::DUAL_BUF_BIT];
   wire logic csTwoUsed = (csFunction == pra_pkg::CSF_CS_TWO_ONLY)
      | (csFunction == pra_pkg::CSF_CS_BOTH);
   wire logic csOneUsed = (csFunction == pra_pkg::CSF_CS_BOTH);
   wire logic useTarget = dualBuffer & readCycleSync;
   wire logic [15:0] next_busAddress = {
      csTwoUsed ? 1'b0 : readTargetAddress[pra_pkg::CS_TWO_BIT],
      csOneUsed ? 1'b0 : readTargetAddress[pra_pkg::CS_ONE_BIT],
      readTargetAddress[pra_pkg::LOW_ADDR_MSB:0]};
   wire logic [31:0] readMux = hitTarget ? {16'h0000, readTargetAddress}
      : hitLow ? {16'h0000, portControlLow}
      : hitHigh ? {16'h0000, portControlHigh}
      : hitStatus ? {29'h00000000, readCycleSync, csOneUsed, csTwoUsed}
      : 32'h00000000;

   // registers, reset to zero so no chip select is driven
   always_ff @(posedge clk) begin
      if (srst) begin
         readTargetAddress <= pra_pkg::READ_TARGET_RESET;
         portControlLow <= pra_pkg::PORT_CONTROL_LOW_RESET;
         portControlHigh <= pra_pkg::PORT_CONTROL_HIGH_RESET;
      end else if (doWrite) begin
         if (hitTarget) readTargetAddress <= pwdata[15:0];
         if (hitLow) portControlLow <= pwdata[15:0];
         if (hitHigh) portControlHigh <= pwdata[15:0];
      end
   end

   // apb answer: no wait state, ready in first access phase cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= setupPhase;
         pslverr <= setupPhase & (~mapped | (pwrite & hitStatus));
         if (setupPhase & ~pwrite) prdata <= readMux;
      end
   end

   // sequencer strobe synchroniser
   always_ff @(posedge clk) begin
      if (srst) begin
         readCycleMeta <= 1'b0;
         readCycleSync <= 1'b0;
      end else begin
         readCycleMeta <= readCycle;
         readCycleSync <= readCycleMeta;
      end
   end

   // parallel bus outputs, idle when unused
   always_ff @(posedge clk) begin
      if (srst) begin
         busAddress <= 16'h0000;
         readChipSelectOne <= 1'b0;
         readChipSelectTwo <= 1'b0;
         readTargetActive <= 1'b0;
      end else begin
         readTargetActive <= useTarget;
         busAddress <= useTarget ? next_busAddress : 16'h0000;
         readChipSelectTwo <= useTarget & csTwoUsed
            & readTargetAddress[pra_pkg::CS_TWO_BIT];
         readChipSelectOne <= useTarget & csOneUsed
            & readTargetAddress[pra_pkg::CS_ONE_BIT];
      end
   end

   a_cs_two_gate: assert property (@(posedge clk) disable iff (srst)
      readChipSelectTwo |-> $past(dualBuffer) && $past(csTwoUsed))
      else $error("chip select two active without assignment");
   a_cs_one_gate: assert property (@(posedge clk) disable iff (srst)
      readChipSelectOne |-> $past(csFunction) == pra_pkg::CSF_CS_BOTH)
      else $error("chip select one active without assignment");
   a_low_address: assert property (@(posedge clk) disable iff (srst)
      readTargetActive |-> busAddress[13:0] == $past(readTargetAddress[13:0]))
      else $error("low address lines differ from register");
   a_upper_addr_mode: assert property (@(posedge clk) disable iff (srst)
      readTargetActive && $past(csFunction) == pra_pkg::CSF_ADDRESS
      |-> busAddress[15:14] == $past(readTargetAddress[15:14]))
      else $error("upper address bits not driven in address mode");
   a_dual_buffer_off: assert property (@(posedge clk) disable iff (srst)
      !$past(dualBuffer) |-> !readTargetActive && busAddress == 16'h0000)
      else $error("register used while dual buffer off");
   a_reset_clear: assert property (@(posedge clk)
      $past(srst) |-> readTargetAddress == 16'h0000 && !readChipSelectOne)
      else $error("register not cleared by reset");
   a_write_store: assert property (@(posedge clk) disable iff (srst)
      doWrite && hitTarget |=> readTargetAddress == $past(pwdata[15:0]))
      else $error("write did not store");
   a_cs_bit_follow: assert property (@(posedge clk) disable iff (srst)
      useTarget && csTwoUsed && readTargetAddress[15] |=> readChipSelectTwo)
      else $error("chip select two not driven");
endmodule // pra_read_address

// file: common/pra_pkg.sv
package pra_pkg;
   localparam logic [11:0] ADDR_READ_TARGET = 12'h000;
   localparam logic [11:0] ADDR_PORT_CONTROL_LOW = 12'h004;
   localparam logic [11:0] ADDR_PORT_CONTROL_HIGH = 12'h008;
   localparam logic [11:0] ADDR_BUS_STATUS = 12'h00C;
   localparam int CS_TWO_BIT = 15;
   localparam int CS_ONE_BIT = 14;
   localparam int LOW_ADDR_MSB = 13;
   localparam int CSF_LSB = 6;
   localparam int DUAL_BUF_BIT = 1;
   localparam logic [15:0] READ_TARGET_RESET = 16'h0000;
   localparam logic [15:0] PORT_CONTROL_LOW_RESET = 16'h0000;
   localparam logic [15:0] PORT_CONTROL_HIGH_RESET = 16'h0000;
   // chip-select function codes
   localparam logic [1:0] CSF_ADDRESS = 2'h0;
   localparam logic [1:0] CSF_CS_TWO_ONLY = 2'h1;
   localparam logic [1:0] CSF_CS_BOTH = 2'h2;
   localparam logic [1:0] CSF_RESERVED = 2'h3;
endpackage

// file: tb/pra_bus_memory.sv
`timescale 1ns/1ps
module pra_bus_memory (
   // parallel bus from the port
   input wire logic clk,
   input wire logic [15:0] busAddress,
   input wire logic readTargetActive,
   // last address seen in a read cycle
   output logic [15:0] seenAddress
);
   always_ff @(posedge clk) begin
      if (readTargetActive) seenAddress <= busAddress;
   end
endmodule // pra_bus_memory

// file: tb/pra_read_address_tb.sv
`timescale 1ns/1ps
module pra_read_address_tb;
   logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, readCycle = 0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, v;
   logic pready, pslverr, cs1, cs2, active;
   logic [15:0] busAddress, seen;
   logic [17:0] e;
   int mismatches = 0, comparisons = 0, seed = 32'h92920DCF;
   always #5 clk = ~clk;
   pra_read_address pra_read_address_inst (.clk(clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .readCycle(readCycle), .busAddress(busAddress),
      .readChipSelectOne(cs1), .readChipSelectTwo(cs2), .readTargetActive(active));
   pra_bus_memory pra_bus_memory_inst (.clk(clk), .busAddress(busAddress),
      .readTargetActive(active), .seenAddress(seen));
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x) begin
         mismatches++;
         $display("BAD %0t seen %h want %h", $time, s, x);
      end
   endtask
   task automatic complete_run;
      if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
      if (pready !== 1'b1) mismatches++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // {chip select two, chip select one, address lines}
   function automatic logic [17:0] expect_bus(input logic [1:0] f, input logic [15:0] x);
      logic two, one;
      two = (f == pra_pkg::CSF_CS_TWO_ONLY) || (f == pra_pkg::CSF_CS_BOTH);
      one = (f == pra_pkg::CSF_CS_BOTH);
      return {two & x[15], one & x[14], x[15] & ~two, x[14] & ~one, x[13:0]};
   endfunction
   task automatic settle;
      readCycle <= 1'b1;
      repeat (5) @(posedge clk);
      @(negedge clk);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      bus(1'b0, pra_pkg::ADDR_READ_TARGET, 32'h0);
      chk(rd, 32'h0);
      for (int f = 0; f < 4; f++) begin
         v = $random(seed);
         bus(1'b1, pra_pkg::ADDR_READ_TARGET, v);
         bus(1'b0, pra_pkg::ADDR_READ_TARGET, 32'h0);
         chk(rd, {16'h0, v[15:0]});
         bus(1'b1, pra_pkg::ADDR_PORT_CONTROL_LOW, 32'(f) << pra_pkg::CSF_LSB);
         bus(1'b1, pra_pkg::ADDR_PORT_CONTROL_HIGH, 32'h1 << pra_pkg::DUAL_BUF_BIT);
         settle();
         e = expect_bus(2'(f), v[15:0]);
         chk({cs2, cs1, busAddress}, {14'h0, e});
         chk(active, 32'h1);
         chk(seen, {16'h0, e[15:0]});
         bus(1'b0, pra_pkg::ADDR_BUS_STATUS, 32'h0);
         chk(rd, {29'h0, 1'b1, 2'(f) == pra_pkg::CSF_CS_BOTH,
            2'(f) == pra_pkg::CSF_CS_TWO_ONLY || 2'(f) == pra_pkg::CSF_CS_BOTH});
         readCycle <= 1'b0;
      end
      bus(1'b1, pra_pkg::ADDR_PORT_CONTROL_HIGH, 32'h0);
      settle();
      chk({active, cs2, cs1, busAddress}, 32'h0);
      bus(1'b0, 12'h010, 32'h0);
      chk(err, 32'h1);
      chk(rd, 32'h0);
      bus(1'b1, pra_pkg::ADDR_BUS_STATUS, 32'hFFFFFFFF);
      chk(err, 32'h1);
      complete_run();
   end
   initial begin
      #100000;
      mismatches++;
      complete_run();
   end
endmodule // pra_read_address_tb
